// [src/gpo_levels_consts.svh]
// Register indices, field layouts, reset values and codes of the
// clock-pin general output block.
// Assumes a 32-bit Wishbone word per register: byte address = 4 * index.
`ifndef GPO_LEVELS_CONSTS_SVH
`define GPO_LEVELS_CONSTS_SVH

`define IDX_WIDTH 9
`define GPO_LOW_IDX 9'h0f0
`define GPO_MID_IDX 9'h0f1
`define GPO_HIGH_IDX 9'h0f2
`define FREEZE_IDX 9'h0f3
`define STATUS_IDX 9'h140
`define SELECT_LOW_IDX 9'h100
`define SELECT_MID_IDX 9'h101
`define SELECT_HIGH_IDX 9'h102
`define GPIO_MODE_IDX 9'h103
`define MBOX_BASE_IDX 9'h110
`define MBOX_END_IDX 9'h124

`define REG_RESET 8'h00
`define CTRL_RESET 3'h0
`define CTRL_OUTPUT_CODE 3'h1
`define HIGH_USED_MASK 8'h0f
`define GPIO_USED_MASK 8'h1f

`define PAIR_COUNT 10
`define PIN_COUNT 20
`define GPIO_COUNT 5
`define CTRL_WIDTH 3
`define MBOX_INDEX_WIDTH 5

`endif

// [src/gpo_levels_pkg.sv]
// Types shared by the clock-pin general output block.
// Assumes gpo_levels_consts.svh is on the include path.
`default_nettype none
package gpo_levels_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_FETCH,
    BUS_ANSWER,
    BUS_RELEASE
  } bus_state_t;
endpackage
`default_nettype wire

// [src/mailbox_if.sv]
// Carrier between the register bank and the pin mailbox store.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_levels_consts.svh"
interface mailbox_if;
  logic wr_en;
  logic [`MBOX_INDEX_WIDTH-1:0] wr_index;
  logic [`CTRL_WIDTH-1:0] wr_data;
  logic [`MBOX_INDEX_WIDTH-1:0] rd_index;
  logic [`CTRL_WIDTH-1:0] rd_data;
  logic [`PIN_COUNT*`CTRL_WIDTH-1:0] ctrl_flat;

  modport store (
    input wr_en, wr_index, wr_data, rd_index,
    output rd_data, ctrl_flat
  );
  modport user (
    output wr_en, wr_index, wr_data, rd_index,
    input rd_data, ctrl_flat
  );
endinterface
`default_nettype wire

// [src/mailbox_store.sv]
// Per-pin mailbox control fields, one entry per output pin.
// Assumes synchronous active-high reset; read data is registered.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_levels_consts.svh"
module mailbox_store
  import gpo_levels_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  mailbox_if.store mbox
);
  logic [`CTRL_WIDTH-1:0] entry_reg [`PIN_COUNT];
  logic [`CTRL_WIDTH-1:0] rd_data_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `PIN_COUNT; i++) begin
        entry_reg[i] <= `CTRL_RESET;
      end
    end else if (mbox.wr_en && mbox.wr_index < `MBOX_INDEX_WIDTH'(`PIN_COUNT)) begin
      entry_reg[mbox.wr_index] <= mbox.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= `CTRL_RESET;
    end else if (mbox.rd_index < `MBOX_INDEX_WIDTH'(`PIN_COUNT)) begin
      rd_data_reg <= entry_reg[mbox.rd_index];
    end else begin
      rd_data_reg <= `CTRL_RESET;
    end
  end

  assign mbox.rd_data = rd_data_reg;

  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : g_flat
      assign mbox.ctrl_flat[g*`CTRL_WIDTH +: `CTRL_WIDTH] = entry_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

// [src/gpo_levels.sv]
// Clock-pin general output levels and general pin input freeze.
// Assumes a classic Wishbone master on clk and asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_levels_consts.svh"
module gpo_levels
  import gpo_levels_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`GPIO_COUNT-1:0] general_pin_in,
  output logic [`PAIR_COUNT-1:0] pair_positive_level,
  output logic [`PAIR_COUNT-1:0] pair_negative_level,
  output logic [`PAIR_COUNT-1:0] pair_positive_drive,
  output logic [`PAIR_COUNT-1:0] pair_negative_drive,
  output logic [`GPIO_COUNT-1:0] input_status
);
  mailbox_if mbox ();

  mailbox_store u_store (
    .clk(clk),
    .reset(reset),
    .mbox(mbox)
  );

  bus_state_t bus_state_reg;
  logic [`IDX_WIDTH-1:0] idx;
  logic [7:0] wr_byte;
  logic wr_fire;
  logic in_mbox;
  logic [7:0] read_mux;
  logic [31:0] dat_reg;
  logic bus_request;
  logic rd_capture;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic wr_freeze;
  logic wr_select_low;
  logic wr_select_mid;
  logic wr_select_high;
  logic wr_mode;

  logic [7:0] general_output_levels_low_reg;
  logic [7:0] general_output_levels_mid_reg;
  logic [7:0] general_output_levels_high_reg;
  logic [7:0] input_status_freeze_reg;
  logic [7:0] select_low_reg;
  logic [7:0] select_mid_reg;
  logic [7:0] select_high_reg;
  logic [7:0] gpio_mode_reg;
  logic [`GPIO_COUNT-1:0] pin_meta_reg;
  logic [`GPIO_COUNT-1:0] pin_sync_reg;
  logic [`GPIO_COUNT-1:0] status_reg;
  logic [`PIN_COUNT-1:0] level_bits;
  logic [`PIN_COUNT-1:0] select_bits;
  logic [`PIN_COUNT-1:0] level_reg;
  logic [`PIN_COUNT-1:0] drive_reg;
  logic [`PIN_COUNT-1:0] pin_enable;
  logic [`CTRL_WIDTH-1:0] pin_ctrl [`PIN_COUNT];
  logic [`GPIO_COUNT-1:0] status_hold;

  assign idx = wb_adr_i[`IDX_WIDTH+1:2];
  assign wr_byte = wb_dat_i[7:0];
  assign in_mbox = (idx >= `MBOX_BASE_IDX) && (idx < `MBOX_END_IDX);
  assign bus_request = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees ack high
  assign wr_fire = wb_ack_o && wb_we_i && wb_sel_i[0];

  // One write strobe per register, all gated by the acked edge
  assign wr_low = wr_fire && (idx == `GPO_LOW_IDX);
  assign wr_mid = wr_fire && (idx == `GPO_MID_IDX);
  assign wr_high = wr_fire && (idx == `GPO_HIGH_IDX);
  assign wr_freeze = wr_fire && (idx == `FREEZE_IDX);
  assign wr_select_low = wr_fire && (idx == `SELECT_LOW_IDX);
  assign wr_select_mid = wr_fire && (idx == `SELECT_MID_IDX);
  assign wr_select_high = wr_fire && (idx == `SELECT_HIGH_IDX);
  assign wr_mode = wr_fire && (idx == `GPIO_MODE_IDX);

  // Request is answered two cycles after it is raised
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_request) begin
            bus_state_reg <= BUS_FETCH;
          end
        end
        // A request dropped before its answer is abandoned
        BUS_FETCH: begin
          if (bus_request) begin
            bus_state_reg <= BUS_ANSWER;
          end else begin
            bus_state_reg <= BUS_IDLE;
          end
        end
        BUS_ANSWER: bus_state_reg <= BUS_RELEASE;
        BUS_RELEASE: bus_state_reg <= BUS_IDLE;
        default: bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (bus_state_reg == BUS_ANSWER) && bus_request;

  // Register read path
  always_comb begin
    read_mux = `REG_RESET;
    if (in_mbox) begin
      read_mux = {5'h00, mbox.rd_data};
    end else begin
      case (idx)
        `GPO_LOW_IDX: read_mux = general_output_levels_low_reg;
        `GPO_MID_IDX: read_mux = general_output_levels_mid_reg;
        `GPO_HIGH_IDX: read_mux = general_output_levels_high_reg;
        `FREEZE_IDX: read_mux = input_status_freeze_reg;
        `STATUS_IDX: read_mux = {3'h0, status_reg};
        `SELECT_LOW_IDX: read_mux = select_low_reg;
        `SELECT_MID_IDX: read_mux = select_mid_reg;
        `SELECT_HIGH_IDX: read_mux = select_high_reg;
        `GPIO_MODE_IDX: read_mux = gpio_mode_reg;
        default: read_mux = `REG_RESET;
      endcase
    end
  end

  // Read data then stands until the next read is fetched
  assign rd_capture = (bus_state_reg == BUS_FETCH) && !wb_we_i;

  // Read data captured once the mailbox read port has settled
  always_ff @(posedge clk) begin
    if (reset) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd_capture) begin
      dat_reg <= {24'h00_0000, read_mux};
    end
  end

  assign wb_dat_o = dat_reg;

  // Mailbox entries are addressed by pin number from the mailbox base
  assign mbox.rd_index = `MBOX_INDEX_WIDTH'(idx - `MBOX_BASE_IDX);
  assign mbox.wr_index = `MBOX_INDEX_WIDTH'(idx - `MBOX_BASE_IDX);
  assign mbox.wr_data = wr_byte[`CTRL_WIDTH-1:0];
  assign mbox.wr_en = wr_fire && in_mbox;

  // Level registers: reserved high bits are dropped on write
  always_ff @(posedge clk) begin
    if (reset) begin
      general_output_levels_low_reg <= `REG_RESET;
    end else if (wr_low) begin
      general_output_levels_low_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      general_output_levels_mid_reg <= `REG_RESET;
    end else if (wr_mid) begin
      general_output_levels_mid_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      general_output_levels_high_reg <= `REG_RESET;
    end else if (wr_high) begin
      general_output_levels_high_reg <= wr_byte & `HIGH_USED_MASK;
    end
  end

  // One select bit per output pin, set for general-purpose output
  always_ff @(posedge clk) begin
    if (reset) begin
      select_low_reg <= `REG_RESET;
    end else if (wr_select_low) begin
      select_low_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      select_mid_reg <= `REG_RESET;
    end else if (wr_select_mid) begin
      select_mid_reg <= wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      select_high_reg <= `REG_RESET;
    end else if (wr_select_high) begin
      select_high_reg <= wr_byte & `HIGH_USED_MASK;
    end
  end

  // Freeze and mode bits exist only for the five general pins
  always_ff @(posedge clk) begin
    if (reset) begin
      input_status_freeze_reg <= `REG_RESET;
    end else if (wr_freeze) begin
      input_status_freeze_reg <= wr_byte & `GPIO_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gpio_mode_reg <= `REG_RESET;
    end else if (wr_mode) begin
      gpio_mode_reg <= wr_byte & `GPIO_USED_MASK;
    end
  end

  assign level_bits = {general_output_levels_high_reg[3:0],
                       general_output_levels_mid_reg,
                       general_output_levels_low_reg};
  assign select_bits = {select_high_reg[3:0], select_mid_reg, select_low_reg};

  genvar p;
  generate
    for (p = 0; p < `PIN_COUNT; p++) begin : g_pin
      assign pin_ctrl[p] = mbox.ctrl_flat[p*`CTRL_WIDTH +: `CTRL_WIDTH];
      assign pin_enable[p] = select_bits[p] &&
                             (pin_ctrl[p] == `CTRL_OUTPUT_CODE);
      always_ff @(posedge clk) begin
        if (reset) begin
          drive_reg[p] <= 1'b0;
        end else begin
          drive_reg[p] <= pin_enable[p];
        end
      end
      // Level is held low while the pin is not driven
      always_ff @(posedge clk) begin
        if (reset) begin
          level_reg[p] <= 1'b0;
        end else begin
          level_reg[p] <= pin_enable[p] && level_bits[p];
        end
      end
    end
    // Bit 2k drives the positive pin of pair k, bit 2k+1 the negative
    for (p = 0; p < `PAIR_COUNT; p++) begin : g_pair
      assign pair_positive_level[p] = level_reg[2*p];
      assign pair_negative_level[p] = level_reg[2*p+1];
      assign pair_positive_drive[p] = drive_reg[2*p];
      assign pair_negative_drive[p] = drive_reg[2*p+1];
    end
  endgenerate

  // Two-stage synchroniser on the general pins; only stage two is read
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_reg <= '0;
    end else begin
      pin_meta_reg <= general_pin_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_sync_reg <= '0;
    end else begin
      pin_sync_reg <= pin_meta_reg;
    end
  end

  genvar n;
  generate
    for (n = 0; n < `GPIO_COUNT; n++) begin : g_status
      // Freeze only acts while the pin is in input or control mode
      assign status_hold[n] = input_status_freeze_reg[n] && gpio_mode_reg[n];
      always_ff @(posedge clk) begin
        if (reset) begin
          status_reg[n] <= 1'b0;
        end else if (status_hold[n]) begin
          status_reg[n] <= status_reg[n];
        end else begin
          status_reg[n] <= pin_sync_reg[n];
        end
      end
    end
  endgenerate

  assign input_status = status_reg;
endmodule
`default_nettype wire

// [verification/gpo_levels_chk.sv]
// Port-level checker for the clock-pin general output block.
// Assumes it is bound onto gpo_levels and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpo_levels_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [4:0] general_pin_in,
  input wire logic [9:0] pair_positive_level,
  input wire logic [9:0] pair_negative_level,
  input wire logic [9:0] pair_positive_drive,
  input wire logic [9:0] pair_negative_drive,
  input wire logic [4:0] input_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a held request");
  property p_rd_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  property p_pos_gate; (pair_positive_level & ~pair_positive_drive) == 0;
  endproperty
  a_pos_gate: assert property (p_pos_gate)
    else $error("positive level set on undriven pin");
  property p_neg_gate; (pair_negative_level & ~pair_negative_drive) == 0;
  endproperty
  a_neg_gate: assert property (p_neg_gate)
    else $error("negative level set on undriven pin");
  property p_drive_cause;
    $changed(pair_positive_drive) |->
      $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("drive changed with no register write");
  property p_level_cause;
    $changed(pair_negative_level) |->
      $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_level_cause: assert property (p_level_cause)
    else $error("level changed with no register write");
  property p_status_src;
    ((input_status ^ $past(input_status)) &
     (input_status ^ $past(general_pin_in, 3))) == 0;
  endproperty
  a_status_src: assert property (p_status_src)
    else $error("status bit changed to a value not seen on its pin");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_driven: cover property (pair_positive_level != 0);
  c_status: cover property (input_status != 0);
endmodule
bind gpo_levels gpo_levels_chk u_gpo_levels_chk (.*);
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the clock-pin general output block.
// Assumes the design sources and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_levels_consts.svh"
module tb;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [31:0] adr = 0, dat = 0, rdat;
  logic [3:0] sel = 0;
  logic [4:0] pin = 0, st, hold;
  logic [9:0] pl, nl, pd, nd;
  logic [7:0] rq[$], b;
  logic [19:0] lvl = 0, gsel = 0, ok = 0;
  int bad_count = 0, checks_done = 0, seed = 6942;
  gpo_levels u_gpo_levels (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .general_pin_in(pin),
    .pair_positive_level(pl), .pair_negative_level(nl),
    .pair_positive_drive(pd), .pair_negative_drive(nd), .input_status(st));
  initial forever #2.5 clk = ~clk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_pins(input logic [19:0] g, input logic [19:0] e);
    cmp({12'h0, g}, {12'h0, e});
  endtask
  task automatic cmp_status(input logic [4:0] g, input logic [4:0] e);
    cmp({27'h0, g}, {27'h0, e});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [8:0] i, input logic [7:0] d,
                    input logic [3:0] s);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {21'h0, i, 2'b00};
    dat <= {24'h0, d};
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic put(input logic [8:0] i, input logic [7:0] d);
    wb(1, i, d, 4'h1);
  endtask
  task automatic rd(input logic [8:0] i, input logic [7:0] e);
    rq.push_back(e);
    wb(0, i, 8'h00, 4'hf);
  endtask
  task automatic chk_pins();
    logic [19:0] gd, gl;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      {gd[2*k+1], gd[2*k], gl[2*k+1], gl[2*k]} = {nd[k], pd[k], nl[k], pl[k]};
    end
    cmp_pins(gd, gsel & ok);
    cmp_pins(gl, lvl & gsel & ok);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) cmp(rdat, {24'h0, rq.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(9'h0f0 + 9'(i), 8'h00);
    rd(`STATUS_IDX, 8'h00);
    rd(9'h1ff, 8'h00);
    put(`SELECT_LOW_IDX, 8'hff);
    put(`SELECT_MID_IDX, 8'hff);
    put(`SELECT_HIGH_IDX, 8'h0f);
    gsel = '1;
    for (int p = 0; p < 20; p++) put(`MBOX_BASE_IDX + 9'(p), 8'h01);
    ok = '1;
    repeat (6) begin
      lvl[15:0] = 16'($random(seed));
      b = 8'($random(seed));
      lvl[19:16] = b[3:0];
      put(`GPO_LOW_IDX, lvl[7:0]);
      put(`GPO_MID_IDX, lvl[15:8]);
      put(`GPO_HIGH_IDX, b);
      rd(`GPO_MID_IDX, lvl[15:8]);
      rd(`GPO_HIGH_IDX, {4'h0, lvl[19:16]});
      chk_pins();
    end
    wb(1, `GPO_LOW_IDX, ~lvl[7:0], 4'h0);
    rd(`GPO_LOW_IDX, lvl[7:0]);
    put(`MBOX_BASE_IDX + 9'd5, 8'h02);
    ok[5] = 0;
    put(`SELECT_LOW_IDX, 8'hfe);
    gsel[0] = 0;
    chk_pins();
    put(`GPIO_MODE_IDX, 8'h1f);
    pin <= 5'($random(seed));
    repeat (4) @(posedge clk);
    cmp_status(st, pin);
    rd(`STATUS_IDX, {3'h0, pin});
    put(`FREEZE_IDX, 8'hff);
    rd(`FREEZE_IDX, 8'h1f);
    hold = pin;
    pin <= ~pin;
    repeat (4) @(posedge clk);
    cmp_status(st, hold);
    put(`GPIO_MODE_IDX, 8'h00);
    repeat (4) @(posedge clk);
    cmp_status(st, pin);
    complete_run();
  end
endmodule
`default_nettype wire
